/* include/sac_map.svh */
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// =============================================
// Result and sequence figures
`define SAC_RES_BITS 12
`define SAC_BIT_MSB 4'hb
`define SAC_BIT_LSB 4'h0
`define SAC_REPLAY_FIRST 4'h1
`define SAC_CFG_LAST 4'h2
`define SAC_CNT_ZERO 4'h0
`define SAC_CNT_STEP 4'h1
`define SAC_CFG_MODE 4'h0
`define SAC_CFG_POL 4'h1
`define SAC_TRIAL_MSB 12'h800
`define SAC_CODE_ZERO 12'h000

// =============================================
// Serial frame lengths in serial clock periods
`define SAC_FRAME_FWD 17
`define SAC_FRAME_BOTH 28

// =============================================
// Configuration bit encodings
`define SAC_MODE_DIFF 1'b0
`define SAC_MODE_SINGLE 1'b1
`define SAC_FMT_BOTH 1'b0
`define SAC_FMT_FWD 1'b1
`define SAC_NULL_BIT 1'b0

// =============================================
// Timing
`define SAC_CLK_NS 40
`define SAC_CS_HIGH_NS 100
`define SAC_CS_HIGH_CYC ((`SAC_CS_HIGH_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CYCLE_MIN_NS 40000
`define SAC_GAP_ZERO 3'h0
`define SAC_GAP_STEP 3'h1

`endif

/* include/sac_pkg.sv */
package sac_pkg;

    // =============================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_CFG    = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONV   = 3'b011,
        ST_REPLAY = 3'b100,
        ST_DONE   = 3'b101
    } sac_state_type;

endpackage

/* logic/sac_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sac_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // =============================================
    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* logic/sac_serial_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"

module sac_serial_control (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DIN,
    input wire logic COMP_ABOVE,
    output logic DOUT,
    output logic DOUT_OE,
    output logic POWER_DOWN,
    output logic BUSY,
    output logic SAMPLE_TRACK,
    output logic INPUT_MODE_SELECT,
    output logic POLARITY_SELECT,
    output logic FORWARD_ONLY_FORMAT,
    output logic POS_IS_INPUT_ONE,
    output logic NEG_IS_GROUND,
    output logic NEG_IS_INPUT_ONE,
    output logic [`SAC_RES_BITS-1:0] DAC_CODE,
    output logic [`SAC_RES_BITS-1:0] RESULT,
    output logic RESULT_VALID
);

    logic cs_n_s;
    logic sclk_s;
    logic din_s;
    logic comp_s;
    logic sclk_d_q;
    logic rise;
    logic fall;
    logic [2:0] gap_q;
    logic armed;
    sac_pkg::sac_state_type state_q;
    logic [3:0] cnt_q;
    logic mode_q;
    logic pol_q;
    logic fmt_q;
    logic [`SAC_RES_BITS-1:0] dac_q;
    logic [`SAC_RES_BITS-1:0] result_q;
    logic valid_q;
    logic dout_q;
    logic oe_q;
    logic track_q;

    // =============================================
    // Pin synchronisers
    sac_sync #(
        .WIDTH(4),
        .RESET_VAL(4'h8)
    ) u_sync (
        .clk(SYS_CLK),
        .rst(RESET),
        .async_in({CS_N, SCLK, DIN, COMP_ABOVE}),
        .sync_out({cs_n_s, sclk_s, din_s, comp_s})
    );

    // =============================================
    // Serial clock edges
    // Serial clock must stay well below SYS_CLK/4 so no edge is missed
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end

    assign rise = sclk_s & ~sclk_d_q;
    assign fall = ~sclk_s & sclk_d_q;

    // =============================================
    // Deselect gap; cleared once a frame starts, so every frame needs a fresh full gap
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            gap_q <= `SAC_GAP_ZERO;
        end else if (state_q != sac_pkg::ST_IDLE) begin
            gap_q <= `SAC_GAP_ZERO;
        end else if (cs_n_s) begin
            if (gap_q != 3'(`SAC_CS_HIGH_CYC)) begin
                gap_q <= gap_q + `SAC_GAP_STEP;
            end
        end
    end

    assign armed = (gap_q == 3'(`SAC_CS_HIGH_CYC));

    // =============================================
    // Sequencer
    always_ff @(posedge SYS_CLK) begin
        if (RESET || cs_n_s) begin
            state_q <= sac_pkg::ST_IDLE;
            cnt_q <= `SAC_CNT_ZERO;
        end else begin
            case (state_q)
                sac_pkg::ST_IDLE: begin
                    if (rise && din_s && armed) begin
                        state_q <= sac_pkg::ST_CFG;
                        cnt_q <= `SAC_CNT_ZERO;
                    end
                end
                sac_pkg::ST_CFG: begin
                    if (rise) begin
                        if (cnt_q == `SAC_CFG_LAST) begin
                            state_q <= sac_pkg::ST_SAMPLE;
                        end else begin
                            cnt_q <= cnt_q + `SAC_CNT_STEP;
                        end
                    end
                end
                sac_pkg::ST_SAMPLE: begin
                    if (fall) begin
                        state_q <= sac_pkg::ST_CONV;
                        cnt_q <= `SAC_BIT_MSB;
                    end
                end
                sac_pkg::ST_CONV: begin
                    if (fall) begin
                        if (cnt_q == `SAC_BIT_LSB) begin
                            if (fmt_q == `SAC_FMT_FWD) begin
                                state_q <= sac_pkg::ST_DONE;
                            end else begin
                                state_q <= sac_pkg::ST_REPLAY;
                                cnt_q <= `SAC_REPLAY_FIRST;
                            end
                        end else begin
                            cnt_q <= cnt_q - `SAC_CNT_STEP;
                        end
                    end
                end
                sac_pkg::ST_REPLAY: begin
                    if (fall) begin
                        if (cnt_q == `SAC_BIT_MSB) begin
                            state_q <= sac_pkg::ST_DONE;
                        end else begin
                            cnt_q <= cnt_q + `SAC_CNT_STEP;
                        end
                    end
                end
                sac_pkg::ST_DONE: begin
                    state_q <= sac_pkg::ST_DONE;
                end
                default: begin
                    state_q <= sac_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // =============================================
    // Configuration capture; held through the frame for the analog mux
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            mode_q <= `SAC_MODE_DIFF;
            pol_q <= 1'b0;
            fmt_q <= `SAC_FMT_FWD;
        end else if (!cs_n_s && rise && state_q == sac_pkg::ST_CFG) begin
            if (cnt_q == `SAC_CFG_MODE) begin
                mode_q <= din_s;
            end else if (cnt_q == `SAC_CFG_POL) begin
                pol_q <= din_s;
            end else begin
                fmt_q <= din_s;
            end
        end
    end

    // =============================================
    // Track window: polarity capture to first falling edge after format bit
    always_ff @(posedge SYS_CLK) begin
        if (RESET || cs_n_s) begin
            track_q <= 1'b0;
        end else if (rise && state_q == sac_pkg::ST_CFG && cnt_q == `SAC_CFG_POL) begin
            track_q <= 1'b1;
        end else if (fall && state_q == sac_pkg::ST_SAMPLE) begin
            track_q <= 1'b0;
        end
    end

    // =============================================
    // Successive approximation
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            dac_q <= `SAC_CODE_ZERO;
            result_q <= `SAC_CODE_ZERO;
            valid_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            if (!cs_n_s && fall && state_q == sac_pkg::ST_SAMPLE) begin
                dac_q <= `SAC_TRIAL_MSB;
            end else if (!cs_n_s && fall && state_q == sac_pkg::ST_CONV) begin
                dac_q[cnt_q] <= comp_s;
                if (cnt_q != `SAC_BIT_LSB) begin
                    dac_q[cnt_q - `SAC_CNT_STEP] <= 1'b1;
                end else begin
                    result_q <= {dac_q[`SAC_RES_BITS-1:1], comp_s};
                    valid_q <= 1'b1;
                end
            end
        end
    end

    // =============================================
    // Serial output, changed on falling serial clock and cleared on deselect
    always_ff @(posedge SYS_CLK) begin
        if (RESET || cs_n_s) begin
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (fall) begin
            case (state_q)
                sac_pkg::ST_SAMPLE: begin
                    dout_q <= `SAC_NULL_BIT;
                    oe_q <= 1'b1;
                end
                sac_pkg::ST_CONV: begin
                    dout_q <= comp_s;
                end
                sac_pkg::ST_REPLAY: begin
                    dout_q <= dac_q[cnt_q];
                end
                sac_pkg::ST_DONE: begin
                    dout_q <= 1'b0;
                end
                default: begin
                    dout_q <= dout_q;
                end
            endcase
        end
    end

    // =============================================
    // Outputs
    assign DOUT = dout_q;
    assign DOUT_OE = oe_q & ~cs_n_s;
    assign POWER_DOWN = cs_n_s;
    assign BUSY = (state_q != sac_pkg::ST_IDLE);
    assign SAMPLE_TRACK = track_q;
    assign INPUT_MODE_SELECT = mode_q;
    assign POLARITY_SELECT = pol_q;
    assign FORWARD_ONLY_FORMAT = fmt_q;
    assign POS_IS_INPUT_ONE = pol_q;
    assign NEG_IS_GROUND = (mode_q == `SAC_MODE_SINGLE);
    assign NEG_IS_INPUT_ONE = (mode_q == `SAC_MODE_DIFF) & ~pol_q;
    assign DAC_CODE = dac_q;
    assign RESULT = result_q;
    assign RESULT_VALID = valid_q;

    // =============================================
    // Assertions
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    a_zero_ignored: assert property (
        (state_q == sac_pkg::ST_IDLE && rise && !din_s) |=> state_q == sac_pkg::ST_IDLE
    ) else $error("Leading zero started a frame");

    a_start_begins: assert property (
        (state_q == sac_pkg::ST_IDLE && rise && din_s && armed && !cs_n_s) |=> state_q == sac_pkg::ST_CFG
    ) else $error("Start bit not accepted");

    a_cfg_three_bits: assert property (
        (state_q == sac_pkg::ST_CFG && rise && !cs_n_s && cnt_q == `SAC_CFG_LAST)
        |=> state_q == sac_pkg::ST_SAMPLE && fmt_q == $past(din_s)
    ) else $error("Format bit not captured as third bit");

    a_mode_capture: assert property (
        (state_q == sac_pkg::ST_CFG && rise && !cs_n_s && cnt_q == `SAC_CFG_MODE)
        |=> NEG_IS_GROUND == $past(din_s)
    ) else $error("Mode bit does not steer the mux");

    a_pol_capture: assert property (
        (state_q == sac_pkg::ST_CFG && rise && !cs_n_s && cnt_q == `SAC_CFG_POL)
        |=> POS_IS_INPUT_ONE == $past(din_s)
    ) else $error("Polarity bit does not steer the mux");

    a_fwd_frame_end: assert property (
        (state_q == sac_pkg::ST_CONV && fall && !cs_n_s && cnt_q == `SAC_BIT_LSB && fmt_q)
        |=> state_q == sac_pkg::ST_DONE && RESULT_VALID
    ) else $error("Forward frame did not end after LSB");

    a_replay_start: assert property (
        (state_q == sac_pkg::ST_CONV && fall && !cs_n_s && cnt_q == `SAC_BIT_LSB && !fmt_q)
        |=> state_q == sac_pkg::ST_REPLAY && cnt_q == `SAC_REPLAY_FIRST
    ) else $error("Replay does not start at bit one");

    a_dout_decision: assert property (
        (state_q == sac_pkg::ST_CONV && fall && !cs_n_s)
        |=> DOUT == $past(comp_s) && dac_q[$past(cnt_q)] == $past(comp_s)
    ) else $error("Decision not on output and in register together");

    a_deselect_idle: assert property (
        $rose(cs_n_s) |=> state_q == sac_pkg::ST_IDLE && !BUSY
    ) else $error("Deselect did not end the frame");

    a_hiz_deselect: assert property (
        cs_n_s |-> !DOUT_OE ##1 !oe_q
    ) else $error("Data out driven while deselected");

    a_shutdown: assert property (
        $rose(cs_n_s) |-> POWER_DOWN ##1 (POWER_DOWN && !SAMPLE_TRACK)
    ) else $error("No shutdown on deselect");

    c_start: cover property (state_q == sac_pkg::ST_IDLE ##1 state_q == sac_pkg::ST_CFG);
    c_fwd_done: cover property (RESULT_VALID && fmt_q);
    c_replay_done: cover property (state_q == sac_pkg::ST_REPLAY ##1 state_q == sac_pkg::ST_DONE);

endmodule

`default_nettype wire

/* tb/sac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// =============================================
// Host side of the serial link
module sac_host_model (
    input wire logic sys_clk,
    input wire logic dout_pin,
    output logic cs_n,
    output logic sclk,
    output logic din
);
    // Pins are synced inside the device, so each serial phase spans several system clocks
    localparam int HALF = 6;
    logic got_q[$];
    int per;

    initial begin
        cs_n = 1'h1;
        sclk = 1'h0;
        din = 1'h0;
        per = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Read data out late in the low phase, away from the edge where it may move
    task automatic grab();
        tick(HALF - 1);
        @(negedge sys_clk);
        got_q.push_back(dout_pin);
        @(posedge sys_clk);
    endtask

    // Fewer periods than a full frame means an abort by deselect
    task automatic run_frame(input int lz, input logic m, input logic p, input logic f, input int nper);
        logic [3:0] hdr;
        hdr = {1'h1, m, p, f};
        got_q.delete();
        @(posedge sys_clk);
        cs_n <= 1'h0;
        tick(HALF);
        for (int i = 1; i <= nper; i++) begin
            per = i;
            din <= (i > lz && i <= lz + 4) ? hdr[lz + 4 - i] : 1'h0;
            if (i > lz + 4) begin
                grab();
            end else begin
                tick(HALF);
            end
            sclk <= 1'h1;
            tick(HALF);
            sclk <= 1'h0;
        end
        grab();
        per = 0;
        cs_n <= 1'h1;
        din <= 1'h0;
        // Gap kept well above the minimum so the re-arm filter always sees it
        tick(10);
    endtask
endmodule

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"

module testbench;
    logic sys_clk, reset, comp_above;
    logic [`SAC_RES_BITS-1:0] vin, dac_code, result;
    wire logic cs_n, sclk, din, dout_pin;
    logic dout, dout_oe, power_down, busy, mode_sel, pol_sel, fwd_fmt, pos_one, neg_gnd, neg_one, result_valid;
    logic sample_track;
    int fails, samples_checked, rv_cnt;
    logic exp_q[$];
    logic [`SAC_RES_BITS-1:0] vins [8] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001, 12'ha5a, 12'h5a5, 12'h3c3};
    int lzs [8] = '{0, 1, 2, 5, 0, 3, 1, 0};

    // =============================================
    // Clock, comparator and pin
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Comparator keeps the trial bit while the input is at or above the trial code
    always @(posedge sys_clk) comp_above <= (vin >= dac_code);
    always @(posedge sys_clk) if (result_valid === 1'h1) rv_cnt++;
    assign dout_pin = dout_oe ? dout : 1'hz;

    sac_host_model u_host (.sys_clk(sys_clk), .dout_pin(dout_pin), .cs_n(cs_n), .sclk(sclk), .din(din));

    sac_serial_control u_dut (
        .SYS_CLK(sys_clk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .COMP_ABOVE(comp_above),
        .DOUT(dout), .DOUT_OE(dout_oe), .POWER_DOWN(power_down), .BUSY(busy), .SAMPLE_TRACK(sample_track),
        .INPUT_MODE_SELECT(mode_sel), .POLARITY_SELECT(pol_sel), .FORWARD_ONLY_FORMAT(fwd_fmt),
        .POS_IS_INPUT_ONE(pos_one), .NEG_IS_GROUND(neg_gnd), .NEG_IS_INPUT_ONE(neg_one),
        .DAC_CODE(dac_code), .RESULT(result), .RESULT_VALID(result_valid)
    );

    // =============================================
    // Compare and closing tasks
    task automatic check_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic check_code(input string name, input logic [`SAC_RES_BITS-1:0] exp,
                              input logic [`SAC_RES_BITS-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_count(input string name, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic check_idle(input string name);
        @(negedge sys_clk);
        check_bit({name, " dout pin"}, 1'hz, dout_pin);
        check_bit({name, " power down"}, 1'h1, power_down);
        check_bit({name, " busy"}, 1'h0, busy);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Whole run is about 2700 cycles; this leaves wide margin
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        finish_test();
    end

    // =============================================
    // Tests
    initial begin
        logic m, p, f;
        int lz;
        reset = 1'h1;
        vin = 12'h000;
        fails = 0;
        samples_checked = 0;
        repeat (20) @(posedge sys_clk);
        reset <= 1'h0;
        repeat (10) @(posedge sys_clk);
        check_idle("after reset");
        $display("test reset done");

        // Deselect mid conversion, then full frames must still start cleanly
        @(posedge sys_clk);
        vin <= 12'h6b1;
        u_host.run_frame(0, 1'h1, 1'h0, 1'h0, 8);
        check_idle("abort");
        check_count("result pulses", 0, rv_cnt);
        $display("test abort done");

        for (int t = 0; t < 8; t++) begin
            m = t[2];
            p = t[1];
            f = t[0];
            lz = lzs[t];
            @(posedge sys_clk);
            vin <= vins[t];
            fork
                u_host.run_frame(lz, m, p, f, lz + (f ? `SAC_FRAME_FWD : `SAC_FRAME_BOTH));
                begin
                    wait (u_host.per == lz + 4);
                    @(negedge sys_clk);
                    check_bit("track open", 1'h1, sample_track);
                    wait (u_host.per == lz + 8);
                    @(negedge sys_clk);
                    check_bit("track closed", 1'h0, sample_track);
                    check_bit("mode", m, mode_sel);
                    check_bit("polarity", p, pol_sel);
                    check_bit("format", f, fwd_fmt);
                    check_bit("pos input one", p, pos_one);
                    check_bit("neg ground", m, neg_gnd);
                    check_bit("neg input one", !m && !p, neg_one);
                    check_bit("busy", 1'h1, busy);
                    check_bit("power down", 1'h0, power_down);
                    check_bit("dout enable", 1'h1, dout_oe);
                end
            join
            exp_q = {1'h0};
            for (int b = `SAC_RES_BITS - 1; b >= 0; b--) exp_q.push_back(vins[t][b]);
            if (!f) for (int b = 1; b < `SAC_RES_BITS; b++) exp_q.push_back(vins[t][b]);
            exp_q.push_back(1'h0);
            check_count("dout bits", exp_q.size(), u_host.got_q.size());
            for (int k = 0; k < exp_q.size() && k < u_host.got_q.size(); k++) begin
                check_bit("dout bit", exp_q[k], u_host.got_q[k]);
            end
            check_code("result", vins[t], result);
            check_count("result pulses", t + 1, rv_cnt);
            check_idle("deselect");
            $display("test frame %0d done", t);
        end
        finish_test();
    end
endmodule

`default_nettype wire
